/* File: mon_pkg.sv */
// Notes on behaviour
// (RQ1) controller keeps trigger high when idle, pulls low to request conversion
// (RQ2) controller holds trigger low at least 4 us before releasing
// (RQ3) trigger held low: each triggered-mode command write starts a conversion
// (RQ4) user pin is input after reset; as output it drives high and low
// (RQ5) critical alarm: open-drain, active low, off at reset, filter programmable
// (RQ6) over-limit alarm: open-drain, active low, off at reset, transparent
// (RQ7) warning alarm: open-drain, active low, off at reset, delay programmable
// (RQ8) alert output off at reset; alert mask selects which events may assert it
// (RQ9) enabled alarm asserts only while its condition holds, releases after
package mon_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned TRIG_LOW_MIN_NS = 4000;
    localparam int unsigned TRIG_LOW_CYC =
        (TRIG_LOW_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [3:0] ADR_CTRL = 4'h0;
    localparam logic [3:0] ADR_COMMAND = 4'h1;
    localparam logic [3:0] ADR_CRIT_TH = 4'h2;
    localparam logic [3:0] ADR_ALERT_MASK = 4'h3;
    localparam logic [3:0] ADR_STATUS = 4'h4;
    localparam logic [3:0] ADR_IRQ_MASK = 4'h5;
    localparam logic [3:0] ADR_GPIO = 4'h6;
    localparam int unsigned CTRL_TRIG_MODE = 0;
    localparam int unsigned CTRL_CRIT_EN = 1;
    localparam int unsigned CTRL_OVER_EN = 2;
    localparam int unsigned CTRL_WARN_EN = 3;
    localparam int unsigned CTRL_ALERT_EN = 4;
    localparam int unsigned CTRL_GPIO_OUT = 5;
    localparam int unsigned CMD_TRIG = 0;
    localparam int unsigned ST_CONV = 0;
    localparam int unsigned ST_CRIT = 1;
    localparam int unsigned ST_OVER = 2;
    localparam int unsigned ST_WARN = 3;
    localparam int unsigned CRIT_FILT_LSB = 0;
    localparam int unsigned WARN_DLY_LSB = 8;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] CRIT_TH_RST = 32'h0000_0000;
    localparam logic [3:0] MASK_RST = 4'h0;
    localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
endpackage

/* File: alarm_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface alarm_if;
    logic en;
    logic [7:0] cycles;
    logic cond;
    logic active;
    modport owner(output en, output cycles, output cond, input active);
    modport filt(input en, input cycles, input cond, output active);
endinterface
`default_nettype wire

/* File: alarm_filter.sv */
`timescale 1ns/100ps
`default_nettype none
module alarm_filter (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    alarm_if.filt a
);
    logic [7:0] cnt_q, cnt_d;
    logic act_q, act_d;
    always_comb begin
        cnt_d = cnt_q;
        act_d = 1'b0;
        if (a.en && a.cond) begin // RQ9
            if (cnt_q >= a.cycles) begin
                act_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 8'h01;
            end
        end else begin
            cnt_d = 8'h00;
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            cnt_q <= 8'h00;
            act_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            act_q <= act_d;
        end
    end
    assign a.active = act_q;
endmodule
`default_nettype wire

/* File: monitor_pins.sv */
`timescale 1ns/100ps
`default_nettype none
module monitor_pins (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic conv_trig_n_i,
    input wire logic crit_cond_i,
    input wire logic over_cond_i,
    input wire logic warn_cond_i,
    input wire logic conv_done_i,
    output logic conv_start_o,
    output logic crit_alarm_o,
    output logic crit_alarm_oe_n_o,
    output logic over_alarm_o,
    output logic over_alarm_oe_n_o,
    output logic warn_alarm_o,
    output logic warn_alarm_oe_n_o,
    output logic alert_o,
    output logic alert_oe_n_o,
    input wire logic gpio_i,
    output logic gpio_o,
    output logic gpio_oe_n_o,
    output logic irq_o
);
    localparam int unsigned TCW = $clog2(mon_pkg::TRIG_LOW_CYC + 1);

    // refuse a low-time count that the counter cannot serve
    if (mon_pkg::TRIG_LOW_CYC == 0) begin : g_bad_trig_cnt
        $error("trigger low count must be at least one");
    end

    // word index of a byte address
    function automatic logic [3:0] word_idx(input logic [5:0] addr);
        return addr[5:2];
    endfunction

    // zero-extend a four-bit register for read-back
    function automatic logic [31:0] pad_nib(input logic [3:0] v);
        return {28'h000_0000, v};
    endfunction

    // pin synchronisers
    logic [1:0] trig_s_q, trig_s_d;
    logic [1:0] gp_s_q, gp_s_d;
    logic [3:0] c1_q, c1_d;
    logic [3:0] c2_q, c2_d;
    // trigger state
    logic [TCW-1:0] low_cnt_q, low_cnt_d;
    logic trig_done_q, trig_done_d;
    logic start_q, start_d;
    // register file
    logic [31:0] ctrl_q, ctrl_d;
    logic [31:0] crit_q, crit_d;
    logic [31:0] rdata_q, rdata_d;
    logic [3:0] amask_q, amask_d;
    logic [3:0] imask_q, imask_d;
    logic [3:0] stat_q, stat_d;
    logic gpio_val_q, gpio_val_d;
    logic ack_q, ack_d;
    logic [3:0] ev;
    logic [3:0] widx;
    logic trig_low;
    logic wr;
    logic rd;
    logic cmd_trig;

    // alarm filters: 0 critical, 1 over-limit, 2 warning
    logic [2:0] alm_en;
    logic [2:0] alm_act;
    logic [2:0][7:0] alm_cyc;
    alarm_if alm [3] ();
    assign alm_en[0] = ctrl_q[mon_pkg::CTRL_CRIT_EN];
    assign alm_en[1] = ctrl_q[mon_pkg::CTRL_OVER_EN];
    assign alm_en[2] = ctrl_q[mon_pkg::CTRL_WARN_EN];
    assign alm_cyc[0] = crit_q[mon_pkg::CRIT_FILT_LSB +: 8]; // RQ5
    assign alm_cyc[1] = 8'h00; // RQ6
    assign alm_cyc[2] = crit_q[mon_pkg::WARN_DLY_LSB +: 8]; // RQ7
    for (genvar i = 0; i < 3; i++) begin : g_alarm
        alarm_filter u_filt (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .a(alm[i]));
        assign alm[i].en = alm_en[i];
        assign alm[i].cycles = alm_cyc[i];
        assign alm[i].cond = c2_q[i + 1];
        assign alm_act[i] = alm[i].active;
    end

    assign widx = word_idx(avs_address);
    assign trig_low = !trig_s_q[1];
    // a write lands at the edge after the wait state ends, in the cycle where waitrequest is low
    assign wr = avs_write && ack_q;
    assign rd = avs_read && !ack_q;
    assign cmd_trig = wr && widx == mon_pkg::ADR_COMMAND
        && avs_writedata[mon_pkg::CMD_TRIG];
    assign ev = {alm_act, c2_q[0]};

    // two flip-flops on every pin input
    always_comb begin
        trig_s_d = {trig_s_q[0], conv_trig_n_i};
        gp_s_d = {gp_s_q[0], gpio_i};
        c1_d = {warn_cond_i, over_cond_i, crit_cond_i, conv_done_i};
        c2_d = c1_q;
    end
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            trig_s_q <= 2'h3;
            gp_s_q <= 2'h3;
            c1_q <= 4'h0;
            c2_q <= 4'h0;
        end else begin
            trig_s_q <= trig_s_d;
            gp_s_q <= gp_s_d;
            c1_q <= c1_d;
            c2_q <= c2_d;
        end
    end

    // low-time counter and conversion start
    always_comb begin
        low_cnt_d = low_cnt_q;
        trig_done_d = trig_done_q;
        start_d = 1'b0;
        if (!trig_low) begin // RQ1
            low_cnt_d = '0;
            trig_done_d = 1'b0;
        end else if (!trig_done_q) begin
            if (low_cnt_q == TCW'(mon_pkg::TRIG_LOW_CYC - 1)) begin // RQ2
                trig_done_d = 1'b1;
                start_d = ctrl_q[mon_pkg::CTRL_TRIG_MODE];
            end else begin
                low_cnt_d = low_cnt_q + TCW'(1);
            end
        end
        if (cmd_trig && ctrl_q[mon_pkg::CTRL_TRIG_MODE] && trig_low) begin
            start_d = 1'b1; // RQ3
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            low_cnt_q <= '0;
            trig_done_q <= 1'b0;
            start_q <= 1'b0;
        end else begin
            low_cnt_q <= low_cnt_d;
            trig_done_q <= trig_done_d;
            start_q <= start_d;
        end
    end

    // register file with set-wins sticky status
    always_comb begin
        ctrl_d = ctrl_q;
        crit_d = crit_q;
        amask_d = amask_q;
        imask_d = imask_q;
        gpio_val_d = gpio_val_q;
        stat_d = stat_q;
        rdata_d = rdata_q;
        ack_d = (avs_read || avs_write) && !ack_q;
        if (wr) begin
            case (widx)
                mon_pkg::ADR_CTRL: ctrl_d = avs_writedata;
                mon_pkg::ADR_CRIT_TH: crit_d = avs_writedata;
                mon_pkg::ADR_ALERT_MASK: amask_d = avs_writedata[3:0]; // RQ8
                mon_pkg::ADR_STATUS: stat_d = stat_q & ~avs_writedata[3:0];
                mon_pkg::ADR_IRQ_MASK: imask_d = avs_writedata[3:0];
                mon_pkg::ADR_GPIO: gpio_val_d = avs_writedata[0];
                default: ;
            endcase
        end
        stat_d = stat_d | ev;
        if (rd) begin
            case (widx)
                mon_pkg::ADR_CTRL: rdata_d = ctrl_q;
                mon_pkg::ADR_CRIT_TH: rdata_d = crit_q;
                mon_pkg::ADR_ALERT_MASK: rdata_d = pad_nib(amask_q);
                mon_pkg::ADR_STATUS: rdata_d = pad_nib(stat_q);
                mon_pkg::ADR_IRQ_MASK: rdata_d = pad_nib(imask_q);
                mon_pkg::ADR_GPIO: rdata_d = {30'h0000_0000, gp_s_q[1], gpio_val_q};
                default: rdata_d = mon_pkg::UNMAPPED_RD;
            endcase
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            ctrl_q <= mon_pkg::CTRL_RST; // RQ4
            crit_q <= mon_pkg::CRIT_TH_RST;
            amask_q <= mon_pkg::MASK_RST;
            imask_q <= mon_pkg::MASK_RST;
            stat_q <= 4'h0;
            gpio_val_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            ack_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            crit_q <= crit_d;
            amask_q <= amask_d;
            imask_q <= imask_d;
            stat_q <= stat_d;
            gpio_val_q <= gpio_val_d;
            rdata_q <= rdata_d;
            ack_q <= ack_d;
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
    assign avs_readdata = rdata_q;
    assign conv_start_o = start_q;
    // open-drain: drive low only while active
    assign crit_alarm_o = 1'b0;
    assign crit_alarm_oe_n_o = !alm_act[0]; // RQ5
    assign over_alarm_o = 1'b0;
    assign over_alarm_oe_n_o = !alm_act[1]; // RQ6
    assign warn_alarm_o = 1'b0;
    assign warn_alarm_oe_n_o = !alm_act[2]; // RQ7
    assign alert_o = 1'b0;
    assign alert_oe_n_o = !(ctrl_q[mon_pkg::CTRL_ALERT_EN] && |(ev & amask_q)); // RQ8
    assign gpio_o = gpio_val_q; // RQ4
    assign gpio_oe_n_o = !ctrl_q[mon_pkg::CTRL_GPIO_OUT]; // RQ4
    assign irq_o = |(stat_q & imask_q);
endmodule
`default_nettype wire

/* File: mon_props.sv */
`timescale 1ns/100ps
`default_nettype none
module mon_props (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic conv_trig_n_i,
    input wire logic crit_cond_i,
    input wire logic over_cond_i,
    input wire logic warn_cond_i,
    input wire logic conv_start_o,
    input wire logic crit_alarm_o,
    input wire logic crit_alarm_oe_n_o,
    input wire logic over_alarm_o,
    input wire logic over_alarm_oe_n_o,
    input wire logic warn_alarm_o,
    input wire logic warn_alarm_oe_n_o,
    input wire logic alert_o,
    input wire logic alert_oe_n_o,
    input wire logic gpio_oe_n_o,
    input wire logic irq_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_crit_drop;
        crit_cond_i ##1 !crit_cond_i;
    endsequence
    sequence s_over_rise;
        !over_cond_i ##1 over_cond_i;
    endsequence
    chk_bus_answer:
        assert property (s_req |=> !avs_waitrequest) else $error("bus answer late");
    chk_reset_idle:
        assert property (disable iff (1'b0) !reset_n_i |=> crit_alarm_oe_n_o
            && over_alarm_oe_n_o && warn_alarm_oe_n_o && alert_oe_n_o && gpio_oe_n_o
            && !irq_o && !conv_start_o) else $error("pin active after reset");
    chk_od_data:
        assert property (!(crit_alarm_o || over_alarm_o || warn_alarm_o || alert_o))
            else $error("open-drain data high");
    chk_crit_release:
        assert property (s_crit_drop |-> ##[1:4] crit_alarm_oe_n_o)
            else $error("critical alarm not released");
    chk_crit_cause:
        assert property (!crit_alarm_oe_n_o |-> crit_cond_i || $past(crit_cond_i)
            || $past(crit_cond_i, 2) || $past(crit_cond_i, 3)) else $error("critical no cause");
    chk_over_fast:
        assert property (s_over_rise |-> ##[1:4] !over_alarm_oe_n_o)
            else $error("over-limit alarm late");
    chk_over_cause:
        assert property (!over_alarm_oe_n_o |-> over_cond_i || $past(over_cond_i)
            || $past(over_cond_i, 2) || $past(over_cond_i, 3)) else $error("over no cause");
    chk_warn_cause:
        assert property (!warn_alarm_oe_n_o |-> warn_cond_i || $past(warn_cond_i)
            || $past(warn_cond_i, 2) || $past(warn_cond_i, 3)) else $error("warn no cause");
    chk_start_pulse:
        assert property (conv_start_o |-> !$past(conv_trig_n_i, 2) || !$past(conv_trig_n_i, 3)
            || !$past(conv_trig_n_i, 4)) else $error("start without low trigger");
endmodule
bind monitor_pins mon_props u_props (.sys_clk_i, .reset_n_i, .avs_read, .avs_write,
    .avs_waitrequest, .conv_trig_n_i, .crit_cond_i, .over_cond_i, .warn_cond_i,
    .conv_start_o, .crit_alarm_o, .crit_alarm_oe_n_o, .over_alarm_o, .over_alarm_oe_n_o,
    .warn_alarm_o, .warn_alarm_oe_n_o, .alert_o, .alert_oe_n_o, .gpio_oe_n_o, .irq_o);
`default_nettype wire

/* File: trig_ctrl_model.sv */
`timescale 1ns/100ps
`default_nettype none
module trig_ctrl_model (
    input wire logic sys_clk_i,
    input wire logic go_i,
    input wire logic park_i,
    output logic conv_trig_n_o
);
    int cnt = 0;
    always @(posedge sys_clk_i) begin
        cnt <= go_i ? int'(mon_pkg::TRIG_LOW_CYC) : (cnt > 0 ? cnt - 1 : 0);
    end
    assign conv_trig_n_o = !(cnt > 0 || park_i);
endmodule
`default_nettype wire

/* File: monitor_pins_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
    $display("unexpected %0t: got %h want %h", $time, g, e); end end
module monitor_pins_tb_top;
    logic sys_clk_i = 0, reset_n_i = 0, avs_read = 0, avs_write = 0, go = 0, park = 0;
    logic crit_cond_i = 0, over_cond_i = 0, warn_cond_i = 0, conv_done_i = 0, gpio_i = 0;
    logic [5:0] avs_address = 6'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, note;
    logic avs_waitrequest, conv_start_o, crit_alarm_o, crit_alarm_oe_n_o, over_alarm_o;
    logic over_alarm_oe_n_o, warn_alarm_o, warn_alarm_oe_n_o, alert_o, alert_oe_n_o;
    logic gpio_o, gpio_oe_n_o, irq_o, conv_trig_n_i;
    logic [31:0] exp_q[$];
    logic [7:0] f;
    int err_total = 0, checks = 0, n;
    wire crit_w = crit_alarm_oe_n_o ? 1'b1 : crit_alarm_o;
    always #50 sys_clk_i = ~sys_clk_i;
    trig_ctrl_model u_ctl (.sys_clk_i, .go_i(go), .park_i(park), .conv_trig_n_o(conv_trig_n_i));
    monitor_pins dut (.sys_clk_i, .reset_n_i, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .conv_trig_n_i, .crit_cond_i,
        .over_cond_i, .warn_cond_i, .conv_done_i, .conv_start_o, .crit_alarm_o,
        .crit_alarm_oe_n_o, .over_alarm_o, .over_alarm_oe_n_o, .warn_alarm_o,
        .warn_alarm_oe_n_o, .alert_o, .alert_oe_n_o, .gpio_i, .gpio_o, .gpio_oe_n_o, .irq_o);
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        avs_address <= {a, 2'b00};
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do begin
            @(posedge sys_clk_i);
        end while (avs_waitrequest !== 1'b0);
        avs_read <= 0;
        avs_write <= 0;
        @(posedge sys_clk_i);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        acc(0, a, 32'h0);
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge sys_clk_i);
    endtask
    task close_out;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge sys_clk_i) begin
        if (avs_read && avs_waitrequest === 1'b0) begin
            note = exp_q.pop_front();
            `CHK(avs_readdata, note)
        end
        if (reset_n_i && conv_start_o !== 1'b0) begin
            note = exp_q.pop_front();
            `CHK(32'h1, note)
        end
    end
    initial begin
        #(5000 * 100);
        err_total++;
        close_out;
    end
    initial begin
        void'($urandom(26));
        cyc(20);
        reset_n_i <= 1;
        cyc(1);
        `CHK({crit_alarm_oe_n_o, over_alarm_oe_n_o, warn_alarm_oe_n_o, alert_oe_n_o}, 4'hF)
        for (int a = 0; a < 16; a++) if (a != 1) rd(a[3:0], 32'h0);
        $display("reset test done");
        f = 8'($urandom);
        acc(1, 4'h0, 32'h20);
        acc(1, 4'h6, {31'h0, f[0]});
        `CHK({gpio_oe_n_o, gpio_o}, {1'b0, f[0]})
        gpio_i <= 1;
        acc(1, 4'h6, {31'h0, ~f[0]});
        `CHK({gpio_oe_n_o, gpio_o}, {1'b0, ~f[0]})
        rd(4'h6, {30'h0, 1'b1, ~f[0]});
        $display("gpio test done");
        acc(1, 4'h0, 32'h1);
        exp_q.push_back(32'h1);
        go <= 1;
        cyc(1);
        go <= 0;
        cyc(60);
        exp_q.push_back(32'h1);
        park <= 1;
        cyc(60);
        repeat (2) begin
            exp_q.push_back(32'h1);
            acc(1, 4'h1, 32'h1);
            cyc(4);
        end
        park <= 0;
        cyc(10);
        `CHK(exp_q.size(), 0)
        $display("trigger test done");
        f = 8'(1 + $urandom % 8);
        acc(1, 4'h2, {16'h0, f, f});
        acc(1, 4'h0, 32'h1E);
        acc(1, 4'h3, 32'h2);
        acc(1, 4'h5, 32'h2);
        crit_cond_i <= 1;
        n = 0;
        while (crit_alarm_oe_n_o !== 1'b0 && n < 40) begin
            cyc(1);
            n++;
        end
        `CHK(n > f && n < 40, 1'b1)
        cyc(1);
        `CHK({crit_w, alert_oe_n_o, irq_o}, 3'b001)
        crit_cond_i <= 0;
        cyc(5);
        `CHK({crit_alarm_oe_n_o, alert_oe_n_o, irq_o}, 3'b111)
        acc(1, 4'h4, 32'h2);
        over_cond_i <= 1;
        cyc(4);
        `CHK({over_alarm_oe_n_o, irq_o}, 2'b00)
        rd(4'h4, 32'h4);
        over_cond_i <= 0;
        warn_cond_i <= 1;
        cyc(4);
        `CHK({over_alarm_oe_n_o, warn_alarm_oe_n_o}, 2'b11)
        cyc(int'(f) + 4);
        `CHK(warn_alarm_oe_n_o, 1'b0)
        warn_cond_i <= 0;
        $display("alarm test done");
        close_out;
    end
endmodule
`default_nettype wire
